// File: rtl/scsr_defs.svh
// Offsets, field positions, reset values and timing counts of the SCSI core status registers.
`ifndef SCSR_DEFS_SVH
`define SCSR_DEFS_SVH
`define SCSR_OFS_FBR       8'h08
`define SCSR_OFS_OCL       8'h09
`define SCSR_OFS_SID       8'h0a
`define SCSR_OFS_BCL       8'h0b
`define SCSR_OFS_DST       8'h0c
`define SCSR_RST_FBR       8'h00
`define SCSR_RST_OCL       8'h00
`define SCSR_RST_SID       8'h00
`define SCSR_RST_DST       8'h80
`define SCSR_DST_DFE       7
`define SCSR_DST_MASTER_DATA_PARITY_ERROR      6
`define SCSR_DST_BF        5
`define SCSR_DST_ABORTED      4
`define SCSR_DST_SSI       3
`define SCSR_DST_SIR       2
`define SCSR_DST_IID       0
`define SCSR_DST_IRQ_MASK  8'h7d
`define SCSR_SID_VAL       7
`define SCSR_DBC_RSVD      22
`define SCSR_DBC_CARRY     21
`define SCSR_DBC_CMP_DATA  18
`define SCSR_DBC_CMP_PHASE 17
`define SCSR_DBC_WAIT_VAL  16
`define SCSR_COMMAND_BYTE_LS_MUST  5
`define SCSR_COMMAND_BYTE_LS_BAD3  3
`define SCSR_COMMAND_BYTE_LS_BAD2  2
`define SCSR_LS_CNT_MIN    24'h000001
`define SCSR_LS_CNT_MAX    24'h000004
`define SCSR_MM_RSVD_MASK  8'h00
`define SCSR_CLK_PERIOD_NS 40
`define SCSR_READ_GAP_CLK  12
`endif

// File: rtl/scsr_pkg.sv
// Types shared by the SCSI core status register files.
package scsr_pkg;
  typedef enum logic [2:0] {
    SCSR_IK_BLOCK_MOVE = 3'h0,
    SCSR_IK_IO         = 3'h1,
    SCSR_IK_RW         = 3'h3,
    SCSR_IK_TCTL       = 3'h2,
    SCSR_IK_MEM_MOVE   = 3'h6,
    SCSR_IK_LOAD_STORE = 3'h7,
    SCSR_IK_RESERVED   = 3'h5
  } scsr_inst_kind_t;
endpackage : scsr_pkg

// File: rtl/scsr_line_if.sv
// Carrier for the SCSI control line sample between the register bank and its synchroniser.
interface scsr_line_if #(
  parameter int W = 8
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport sync_mp (input raw, output synced);
  modport user_mp (output raw, input synced);
endinterface : scsr_line_if

// File: rtl/scsr_sync.sv
// Multi-stage synchroniser for the live SCSI control lines.
module scsr_sync #(
  parameter int W      = 8,
  parameter int STAGES = 2
) (
  input  wire logic    mclk,
  input  wire logic    srst,
  scsr_line_if.sync_mp lines
);
  typedef struct packed {
    logic [STAGES-1:0][W-1:0] stage;
  } scsr_sync_state_t;

  scsr_sync_state_t st_r;
  scsr_sync_state_t st_nxt;

  if (STAGES < 2) begin : g_bad_stages
    $error("scsr_sync needs at least two stages");
  end

  // Each stage reads only the one before it, so the first flop never feeds logic.
  always_comb begin
    st_nxt = st_r;
    st_nxt.stage[0] = lines.raw;
    for (int i = 1; i < STAGES; i++) begin
      st_nxt.stage[i] = st_r.stage[i-1];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lines.synced = st_r.stage[STAGES-1];
endmodule : scsr_sync

// File: rtl/scsr_regs.sv
// Byte-wide SCSI core status register bank with first-byte capture and DMA status.
`include "scsr_defs.svh"

// Summary of operation
// - Capture first byte of each asynchronous input phase.
// - Every input block move reloads the first byte, unless the engine writes it in that cycle.
// - First byte register is the engine accumulator.
// - Host writes never load the first byte.
// - Selection with compat clear copies low data.
// - Latch bits drive control lines, reset zero.
// - Valid bit shows two IDs were seen.
// - Low nibble holds selecting device's encoded ID.
// - Bus control lines read live, latch order.
// - Live lines are synchronised before read data.
// - Status read clears set bits except FIFO empty and stacked repeats, and pending.
// - Each status cause masked by enable register.
// - FIFO empty bit resets one, never interrupts.
// - Parity error bit gated by check enable.
// - Bus fault only as master, bad end.
// - Software abort request sets the aborted bit.
// - Single step sets bit after each instruction.
// - True interrupt instruction sets its bit.
// - Reserved opcodes and bad moves flag illegal.
// - Bad load, store or memory move flag illegal.
module scsr_regs #(
  parameter int         CTL_W       = 8,
  parameter int         SYNC_STAGES = 2,
  parameter logic [7:0] MM_RSVD     = `SCSR_MM_RSVD_MASK
) (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic [7:0]               host_addr,
  input  wire logic                     host_wr,
  input  wire logic                     host_rd,
  input  wire logic [7:0]               host_wdata,
  output logic [7:0]                    host_rdata,
  input  wire logic                     eng_wr,
  input  wire logic [7:0]               eng_addr,
  input  wire logic [7:0]               eng_wdata,
  output logic [7:0]                    fbr_value,
  input  wire logic                     rx_first_stb,
  input  wire logic [7:0]               rx_byte,
  input  wire logic                     sel_phase,
  input  wire logic                     sel_compat,
  input  wire logic [7:0]               scsi_data_lo,
  input  wire logic                     sel_done,
  input  wire logic                     sel_two_ids,
  input  wire logic [3:0]               sel_enc_id,
  input  wire logic [CTL_W-1:0]         ctl_lines_in,
  output logic [CTL_W-1:0]              ctl_out,
  input  wire logic                     fifo_empty,
  input  wire logic                     master_parity_chk_en,
  input  wire logic                     master_active,
  input  wire logic                     data_parity_err,
  input  wire logic                     target_parity_err,
  input  wire logic                     cycle_end,
  input  wire logic                     bad_address,
  input  wire logic                     target_abort,
  input  wire logic                     abort_cmd,
  input  wire logic                     single_step_en,
  input  wire logic                     inst_done,
  input  wire logic                     int_true,
  input  wire logic                     inst_check,
  input  scsr_pkg::scsr_inst_kind_t     inst_kind,
  input  wire logic [7:0]               command_byte,
  input  wire logic [23:0]              byte_counter,
  input  wire logic                     target_mode,
  input  wire logic                     wait_disc_req,
  input  wire logic                     ls_ops_reg,
  input  wire logic                     ls_misaligned,
  input  wire logic                     ls_cross_dword,
  input  wire logic                     mm_unaligned,
  input  wire logic [7:0]               dma_int_enable,
  output logic                          dma_int_pending
);
  import scsr_pkg::*;

  typedef struct packed {
    logic [7:0]       fbr;
    logic [CTL_W-1:0] ocl;
    logic [7:0]       sid;
    logic [7:0]       dst;
    logic [7:0]       stk;
    logic [7:0]       rdata;
    logic             dma_interrupt_pending;
  } scsr_regs_state_t;

  localparam scsr_regs_state_t ST_RST = '{
    fbr:   `SCSR_RST_FBR,
    ocl:   `SCSR_RST_OCL,
    sid:   `SCSR_RST_SID,
    dst:   `SCSR_RST_DST,
    stk:   8'h00,
    rdata: 8'h00,
    dma_interrupt_pending:   1'b0
  };

  scsr_regs_state_t st_r;
  scsr_regs_state_t st_nxt;
  logic [7:0]       ev;
  logic             iid_ev;
  logic             dst_rd;
  logic             sel_copy;
  logic [CTL_W-1:0] bcl_sync;

  if (CTL_W != 8) begin : g_bad_width
    $error("scsr_regs serves exactly eight control lines");
  end

  scsr_line_if #(.W(CTL_W)) u_lif ();

  assign u_lif.raw = ctl_lines_in;
  assign bcl_sync  = u_lif.synced;

  scsr_sync #(
    .W      (CTL_W),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .mclk  (mclk),
    .srst  (srst),
    .lines (u_lif)
  );

  // Illegal instruction decode; the engine samples these fields on inst_check.
  always_comb begin
    iid_ev = 1'b0;
    if (inst_check) begin
      case (inst_kind)
        SCSR_IK_RESERVED: begin
          iid_ev = 1'b1;
        end
        SCSR_IK_BLOCK_MOVE: begin
          iid_ev = (byte_counter == 24'h000000);
        end
        SCSR_IK_TCTL: begin
          iid_ev = byte_counter[`SCSR_DBC_RSVD]
                 | (target_mode & byte_counter[`SCSR_DBC_CMP_DATA]
                    & byte_counter[`SCSR_DBC_CMP_PHASE])
                 | (target_mode & byte_counter[`SCSR_DBC_WAIT_VAL])
                 | (byte_counter[`SCSR_DBC_CARRY]
                    & (byte_counter[`SCSR_DBC_CMP_DATA] | byte_counter[`SCSR_DBC_CMP_PHASE]));
        end
        SCSR_IK_LOAD_STORE: begin
          iid_ev = ls_ops_reg | ls_misaligned | ls_cross_dword
                 | ~command_byte[`SCSR_COMMAND_BYTE_LS_MUST]
                 | command_byte[`SCSR_COMMAND_BYTE_LS_BAD3] | command_byte[`SCSR_COMMAND_BYTE_LS_BAD2]
                 | (byte_counter < `SCSR_LS_CNT_MIN) | (byte_counter > `SCSR_LS_CNT_MAX);
        end
        SCSR_IK_MEM_MOVE: begin
          iid_ev = ((command_byte & MM_RSVD) != 8'h00) | mm_unaligned;
        end
        default: begin
          iid_ev = 1'b0;
        end
      endcase
    end
    if (wait_disc_req) begin
      iid_ev = 1'b1;
    end
  end

  always_comb begin
    ev = 8'h00;
    ev[`SCSR_DST_MASTER_DATA_PARITY_ERROR] = master_parity_chk_en & master_active
                       & (data_parity_err | target_parity_err);
    ev[`SCSR_DST_BF]   = master_active & cycle_end & (bad_address | target_abort);
    ev[`SCSR_DST_ABORTED] = abort_cmd;
    ev[`SCSR_DST_SSI]  = single_step_en & inst_done;
    ev[`SCSR_DST_SIR]  = int_true;
    ev[`SCSR_DST_IID]  = iid_ev;
  end

  assign dst_rd   = host_rd && (host_addr == `SCSR_OFS_DST);
  assign sel_copy = sel_phase && !sel_compat;

  always_comb begin
    st_nxt = st_r;
    // Lowest to highest priority: selection copy, received byte, engine write.
    if (sel_copy) begin
      st_nxt.fbr = scsi_data_lo;
    end
    if (rx_first_stb) begin
      st_nxt.fbr = rx_byte;
    end
    if (eng_wr && eng_addr == `SCSR_OFS_FBR) begin
      st_nxt.fbr = eng_wdata;
    end
    // Host writes reach only the output latch; the other offsets drop them.
    if (host_wr && host_addr == `SCSR_OFS_OCL) begin
      st_nxt.ocl = host_wdata;
    end
    if (eng_wr && eng_addr == `SCSR_OFS_OCL) begin
      st_nxt.ocl = eng_wdata;
    end
    if (sel_done) begin
      st_nxt.sid = {sel_two_ids, 3'h0, sel_enc_id};
    end
    // A cause that repeats while its bit is still set is stacked, so a read
    // cannot swallow it; a cause in the read cycle itself lands after the clear.
    if (dst_rd) begin
      st_nxt.dst = st_r.stk | ev;
      st_nxt.stk = 8'h00;
    end else begin
      st_nxt.dst = st_r.dst | ev;
      st_nxt.stk = st_r.stk | (ev & st_r.dst);
    end
    st_nxt.dst[`SCSR_DST_DFE] = fifo_empty;
    st_nxt.dst[1] = 1'b0;
    st_nxt.dma_interrupt_pending = |(st_nxt.dst & dma_int_enable & `SCSR_DST_IRQ_MASK);
    if (host_rd) begin
      if (host_addr == `SCSR_OFS_FBR) begin
        st_nxt.rdata = st_r.fbr;
      end else if (host_addr == `SCSR_OFS_OCL) begin
        st_nxt.rdata = st_r.ocl;
      end else if (host_addr == `SCSR_OFS_SID) begin
        st_nxt.rdata = st_r.sid;
      end else if (host_addr == `SCSR_OFS_BCL) begin
        st_nxt.rdata = bcl_sync;
      end else if (host_addr == `SCSR_OFS_DST) begin
        st_nxt.rdata = st_r.dst;
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign host_rdata      = st_r.rdata;
  assign fbr_value       = st_r.fbr;
  assign ctl_out         = st_r.ocl;
  assign dma_int_pending = st_r.dma_interrupt_pending;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_lines_steady;
    $stable(ctl_lines_in) [*3];
  endsequence

  sequence s_bcl_read;
    host_rd && host_addr == `SCSR_OFS_BCL;
  endsequence

  a_fbr_first_byte: assert property (
    rx_first_stb && !eng_wr |=> st_r.fbr == $past(rx_byte))
    else $error("first byte not captured");
  a_fbr_repeat_move: assert property (
    rx_first_stb ##1 rx_first_stb && !eng_wr |=> st_r.fbr == $past(rx_byte))
    else $error("repeated phase byte not captured");
  a_fbr_accum_load: assert property (
    eng_wr && eng_addr == `SCSR_OFS_FBR |=> st_r.fbr == $past(eng_wdata))
    else $error("accumulator write lost");
  a_fbr_host_ignored: assert property (
    host_wr && !eng_wr && !rx_first_stb && !sel_copy |=> $stable(fbr_value))
    else $error("host write changed first byte");
  a_fbr_sel_copy: assert property (
    sel_copy && !eng_wr && !rx_first_stb |=> st_r.fbr == $past(scsi_data_lo))
    else $error("selection data not copied");
  a_ocl_drives_pins: assert property (
    host_wr && host_addr == `SCSR_OFS_OCL && !eng_wr |=> ctl_out == $past(host_wdata))
    else $error("latch write not on pins");
  a_sid_capture: assert property (
    sel_done |=> st_r.sid == {$past(sel_two_ids), 3'h0, $past(sel_enc_id)})
    else $error("selector id not captured");
  a_sid_valid_bit: assert property (
    sel_done && !sel_two_ids |=> !st_r.sid[`SCSR_SID_VAL])
    else $error("valid bit set with one id");
  a_bcl_live_read: assert property (
    s_lines_steady ##0 s_bcl_read |=> host_rdata == $past(ctl_lines_in))
    else $error("control line read wrong");
  a_dst_read_clear: assert property (
    dst_rd && st_r.stk == 8'h00 && ev == 8'h00 |=> (st_r.dst & 8'h7f) == 8'h00 && !st_r.dma_interrupt_pending)
    else $error("status read did not clear");
  a_dst_set_wins: assert property (
    ev != 8'h00 |=> (st_r.dst & $past(ev)) == $past(ev))
    else $error("status event lost");
  a_dip_masked: assert property (
    ##1 st_r.dma_interrupt_pending == |(st_r.dst & $past(dma_int_enable) & `SCSR_DST_IRQ_MASK))
    else $error("pending flag ignores mask");
  a_dfe_status: assert property (
    ##1 st_r.dst[`SCSR_DST_DFE] == $past(fifo_empty))
    else $error("fifo empty bit wrong");
  a_master_data_parity_error_disabled: assert property (
    dst_rd && !master_parity_chk_en && !st_r.stk[`SCSR_DST_MASTER_DATA_PARITY_ERROR] |=> !st_r.dst[`SCSR_DST_MASTER_DATA_PARITY_ERROR])
    else $error("parity bit set while disabled");
  a_bf_master_only: assert property (
    dst_rd && !master_active && !st_r.stk[`SCSR_DST_BF] |=> !st_r.dst[`SCSR_DST_BF])
    else $error("bus fault without master");
  a_aborted_set: assert property (
    abort_cmd |=> st_r.dst[`SCSR_DST_ABORTED]) else $error("abort not flagged");
  a_ssi_set: assert property (
    inst_done && single_step_en |=> st_r.dst[`SCSR_DST_SSI]) else $error("single step lost");
  a_sir_set: assert property (
    int_true |=> st_r.dst[`SCSR_DST_SIR]) else $error("script interrupt lost");
  a_iid_zero_move: assert property (
    inst_check && inst_kind == SCSR_IK_BLOCK_MOVE && byte_counter == 24'h000000
    |=> st_r.dst[`SCSR_DST_IID]) else $error("zero count move not illegal");
  a_iid_ls_count: assert property (
    inst_check && inst_kind == SCSR_IK_LOAD_STORE && byte_counter > 24'h000004
    |=> st_r.dst[`SCSR_DST_IID]) else $error("load store count not illegal");
  a_sid_host_ro: assert property (
    host_wr && !sel_done |=> $stable(st_r.sid)) else $error("selector id written");
endmodule : scsr_regs

// File: tb/scsr_bus_model.sv
// Behavioural model of the SCSI bus devices facing the status register bank.
module scsr_bus_model (
  input  wire logic mclk,
  output logic [7:0] ctl_lines_in,
  output logic [7:0] scsi_data_lo,
  output logic       sel_phase,
  output logic       sel_done,
  output logic       sel_two_ids,
  output logic [3:0] sel_enc_id,
  output logic       rx_first_stb,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ctl_lines_in = 8'h00;
    scsi_data_lo = 8'h5a;
    sel_phase    = 1'b0;
    sel_done     = 1'b0;
    sel_two_ids  = 1'b0;
    sel_enc_id   = 4'h0;
    rx_first_stb = 1'b0;
    rx_byte      = 8'h33;
  end
  // Released lines never keep their last value, so a stale capture cannot pass.
  always @(posedge mclk) begin
    if (!sel_phase) scsi_data_lo <= ~scsi_data_lo;
    if (!rx_first_stb) rx_byte <= ~rx_byte;
  end
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick
  task automatic drive_lines(input logic [7:0] v);
    ctl_lines_in = v;
  endtask : drive_lines
  task automatic first_byte(input logic [7:0] b);
    rx_byte = b;
    rx_first_stb = 1'b1;
    tick();
    rx_first_stb = 1'b0;
  endtask : first_byte
  // Two moves back to back, so the second capture follows the first with no gap.
  task automatic two_bytes(input logic [7:0] a, input logic [7:0] b);
    rx_byte = a;
    rx_first_stb = 1'b1;
    tick();
    rx_byte = b;
    tick();
    rx_first_stb = 1'b0;
  endtask : two_bytes
  task automatic sel_bus(input logic [7:0] b);
    sel_phase = 1'b1;
    scsi_data_lo = b;
    repeat (2) tick();
    sel_phase = 1'b0;
  endtask : sel_bus
  task automatic select(input logic two, input logic [3:0] id);
    sel_two_ids = two;
    sel_enc_id = id;
    sel_done = 1'b1;
    tick();
    sel_done = 1'b0;
  endtask : select
endmodule : scsr_bus_model

// File: tb/tb_top.sv
// Self-checking bench for the SCSI core status register bank.
`include "scsr_defs.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("Error at %0t ns: got %h expected %h", $time, got, exp); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import scsr_pkg::*;
  logic mclk, srst, host_wr, host_rd, eng_wr, sel_phase, sel_compat, sel_done, sel_two_ids;
  logic rx_first_stb, fifo_empty, master_parity_chk_en, master_active, data_parity_err;
  logic target_parity_err, cycle_end, bad_address, target_abort, abort_cmd, single_step_en;
  logic inst_done, int_true, inst_check, target_mode, wait_disc_req, ls_ops_reg;
  logic ls_misaligned, ls_cross_dword, mm_unaligned, dma_int_pending;
  logic [7:0]  host_addr, host_wdata, host_rdata, eng_addr, eng_wdata, fbr_value, rx_byte;
  logic [7:0]  scsi_data_lo, ctl_lines_in, ctl_out, command_byte, dma_int_enable;
  logic [3:0]  sel_enc_id;
  logic [23:0] byte_counter;
  scsr_inst_kind_t inst_kind;
  int errors, tests_run, cycles;
  logic [7:0] ev_exp [25] = '{8'h40, 8'h40, 8'h00, 8'h20, 8'h20, 8'h00, 8'h10, 8'h08, 8'h00,
    8'h04, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00,
    8'h00, 8'h01, 8'h01, 8'h01};

  scsr_regs u_scsr_regs (.mclk, .srst, .host_addr, .host_wr, .host_rd, .host_wdata,
    .host_rdata, .eng_wr, .eng_addr, .eng_wdata, .fbr_value, .rx_first_stb, .rx_byte,
    .sel_phase, .sel_compat, .scsi_data_lo, .sel_done, .sel_two_ids, .sel_enc_id,
    .ctl_lines_in, .ctl_out, .fifo_empty, .master_parity_chk_en, .master_active,
    .data_parity_err, .target_parity_err, .cycle_end, .bad_address, .target_abort,
    .abort_cmd, .single_step_en, .inst_done, .int_true, .inst_check, .inst_kind,
    .command_byte, .byte_counter, .target_mode, .wait_disc_req, .ls_ops_reg,
    .ls_misaligned, .ls_cross_dword, .mm_unaligned, .dma_int_enable, .dma_int_pending);
  scsr_bus_model u_scsr_bus_model (.mclk, .ctl_lines_in, .scsi_data_lo, .sel_phase,
    .sel_done, .sel_two_ids, .sel_enc_id, .rx_first_stb, .rx_byte);

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;
  // The ceiling is about eight times the expected run, so a stalled test ends cleanly.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      test_done();
    end
  end

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick
  task automatic test_done();
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task automatic hwrite(input logic [7:0] a, input logic [7:0] d);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    tick();
    host_wr = 1'b0;
    tick();
  endtask : hwrite
  task automatic ewrite(input logic [7:0] a, input logic [7:0] d);
    eng_addr = a;
    eng_wdata = d;
    eng_wr = 1'b1;
    tick();
    eng_wr = 1'b0;
    tick();
  endtask : ewrite
  task automatic hread(input logic [7:0] a, input logic [7:0] exp);
    host_addr = a;
    host_rd = 1'b1;
    tick();
    host_rd = 1'b0;
    tick();
    `CHK(host_rdata, exp)
  endtask : hread
  task automatic sread(input logic [7:0] exp);
    hread(`SCSR_OFS_DST, exp);
    repeat (`SCSR_READ_GAP_CLK) tick();
  endtask : sread
  task automatic ev(input int k);
    master_parity_chk_en = (k != 2);
    inst_kind = (k == 10) ? SCSR_IK_RESERVED : (k inside {[12:14]}) ? SCSR_IK_TCTL :
      (k == 18) ? SCSR_IK_MEM_MOVE : (k inside {[16:20], [22:24]}) ? SCSR_IK_LOAD_STORE :
      SCSR_IK_BLOCK_MOVE;
    case (k)
      0, 2: {master_active, data_parity_err} = 2'b11;
      1: {master_active, target_parity_err} = 2'b11;
      3: {master_active, cycle_end, bad_address} = 3'b111;
      4: {master_active, cycle_end, target_abort} = 3'b111;
      5: {cycle_end, bad_address} = 2'b11;
      6: abort_cmd = 1'b1;
      7: {single_step_en, inst_done} = 2'b11;
      8: inst_done = 1'b1;
      9: int_true = 1'b1;
      11: {inst_check, byte_counter} = {1'b1, 24'h000000};
      12: {inst_check, byte_counter} = {1'b1, 24'h400001};
      13: {inst_check, target_mode, byte_counter} = {2'b11, 24'h010001};
      14: {inst_check, byte_counter} = {1'b1, 24'h240001};
      15: wait_disc_req = 1'b1;
      16: {inst_check, byte_counter} = {1'b1, 24'h000005};
      17: {inst_check, ls_ops_reg} = 2'b11;
      18: {inst_check, mm_unaligned} = 2'b11;
      19: {inst_check, command_byte} = {1'b1, 8'h00};
      22: {inst_check, ls_cross_dword} = 2'b11;
      23: {inst_check, command_byte} = {1'b1, 8'h24};
      24: {inst_check, ls_misaligned} = 2'b11;
      default: inst_check = 1'b1;
    endcase
    tick();
    {master_active, data_parity_err, target_parity_err, cycle_end, bad_address, target_abort,
      abort_cmd, single_step_en, inst_done, int_true, inst_check, target_mode, wait_disc_req,
      ls_ops_reg, ls_misaligned, ls_cross_dword, mm_unaligned} = '0;
    byte_counter = 24'h000001;
    command_byte = 8'h20;
    master_parity_chk_en = 1'b1;
    repeat (2) tick();
  endtask : ev

  initial begin
    {srst, fifo_empty} = 2'b11;
    {host_wr, host_rd, eng_wr, sel_compat} = '0;
    {host_addr, host_wdata, eng_addr, eng_wdata} = '0;
    dma_int_enable = 8'hff;
    ev(-1);
    repeat (2) tick();
    srst = 1'b0;
    hread(`SCSR_OFS_FBR, `SCSR_RST_FBR);
    hread(`SCSR_OFS_OCL, `SCSR_RST_OCL);
    hread(`SCSR_OFS_SID, `SCSR_RST_SID);
    `CHK(dma_int_pending, 1'b0)
    sread(`SCSR_RST_DST);
    ewrite(`SCSR_OFS_FBR, 8'h3c);
    `CHK(fbr_value, 8'h3c)
    hwrite(`SCSR_OFS_FBR, 8'h55);
    hread(`SCSR_OFS_FBR, 8'h3c);
    u_scsr_bus_model.first_byte(8'h9e);
    tick();
    `CHK(fbr_value, 8'h9e)
    u_scsr_bus_model.two_bytes(8'h47, 8'h61);
    hread(`SCSR_OFS_FBR, 8'h61);
    u_scsr_bus_model.sel_bus(8'hc3);
    `CHK(fbr_value, 8'hc3)
    sel_compat = 1'b1;
    u_scsr_bus_model.sel_bus(8'h11);
    hread(`SCSR_OFS_FBR, 8'hc3);
    hwrite(`SCSR_OFS_OCL, 8'h81);
    `CHK(ctl_out, 8'h81)
    ewrite(`SCSR_OFS_OCL, 8'h24);
    hread(`SCSR_OFS_OCL, 8'h24);
    u_scsr_bus_model.select(1'b1, 4'hb);
    hwrite(`SCSR_OFS_SID, 8'h00);
    hread(`SCSR_OFS_SID, 8'h8b);
    u_scsr_bus_model.select(1'b0, 4'h6);
    hread(`SCSR_OFS_SID, 8'h06);
    u_scsr_bus_model.drive_lines(8'ha6);
    tick();
    hwrite(`SCSR_OFS_BCL, 8'h00);
    hread(`SCSR_OFS_BCL, 8'ha6);
    hread(8'h20, 8'h00);
    hwrite(`SCSR_OFS_DST, 8'h7f);
    sread(8'h80);
    foreach (ev_exp[k]) begin
      ev(k);
      `CHK(dma_int_pending, |ev_exp[k])
      sread(8'h80 | ev_exp[k]);
      `CHK(dma_int_pending, 1'b0)
      sread(8'h80);
    end
    ev(6);
    ev(6);
    sread(8'h90);
    sread(8'h90);
    sread(8'h80);
    dma_int_enable = 8'hef;
    ev(6);
    `CHK(dma_int_pending, 1'b0)
    sread(8'h90);
    {master_active, data_parity_err, master_parity_chk_en} = 3'b110;
    fifo_empty = 1'b0;
    tick();
    sread(8'h00);
    test_done();
  end
endmodule : tb_top
